// *** spms_params.svh ***
/*
 * Register offsets, field positions, reset values and rate codes of the
 * byte-wide serial port. Assumes inclusion by bare name from the design.
 */
`ifndef SPMS_PARAMS_SVH
`define SPMS_PARAMS_SVH

// Register indices on the plain register port.
`define SPMS_ADDR_DATA      2'h1
`define SPMS_ADDR_CTRL      2'h2
`define SPMS_ADDR_STAT      2'h3

// Control field positions.
`define SPMS_CR_IRQ_EN      7
`define SPMS_CR_OUT_EN      6
`define SPMS_CR_RATE_DIV    5
`define SPMS_CR_MASTER      4
`define SPMS_CR_IDLE_LVL    3
`define SPMS_CR_CAPT_EDGE   2

// Status field positions.
`define SPMS_SR_DONE        7
`define SPMS_SR_WRITE_COLLISION_FLAG        6
`define SPMS_SR_OVR         5
`define SPMS_SR_MODE_FAULT_FLAG        4
`define SPMS_SR_SOD         2
`define SPMS_SR_SSM         1
`define SPMS_SR_SSI         0

// Reset values.
`define SPMS_CTRL_RESET     8'h00
`define SPMS_STAT_RESET     8'h00

// Serial clock half periods in CPU clocks for each rate code {div, rate[1:0]}.
`define SPMS_HALF_DIV4      7'h02
`define SPMS_HALF_DIV8      7'h04
`define SPMS_HALF_DIV16     7'h08
`define SPMS_HALF_DIV32     7'h10
`define SPMS_HALF_DIV64     7'h20
`define SPMS_HALF_DIV128    7'h40

`endif

// *** spms_pkg.sv ***
/*
 * Types shared by the serial port design. Assumes the constants header
 * is compiled alongside.
 */
`default_nettype none
package spms_pkg;

  // Serial link pins seen by the port: inputs and three-signal outputs.
  typedef struct packed {
    logic sck_in;
    logic mosi_in;
    logic miso_in;
    logic ss_n_in;
  } spms_pins_in_t;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic mosi_out;
    logic mosi_oe;
    logic miso_out;
    logic miso_oe;
  } spms_pins_out_t;

  // Exchange sequencer states.
  typedef enum logic [2:0] {
    SPMS_IDLE  = 3'b001,
    SPMS_SHIFT = 3'b010,
    SPMS_DONE  = 3'b100
  } spms_state_t;

endpackage
`default_nettype wire

// *** spms_port.sv ***
/*
 * Byte-wide serial port, master or slave, with control/status and data
 * registers behind a plain register port. Assumes the link pins are
 * synchronous to i_mclk and the low-power inputs come from the CPU core.
 */
// Our own choices: strobed register access and the placing of the registers.
// Functional notes
// - In WAIT the port runs unchanged; any port interrupt wakes the CPU.
// - In HALT registers freeze and the port is inactive until woken.
// - Several bytes received before HALT wake-up servicing raise overrun.
// - As slave, only transfer-done may wake from HALT; faults wake from WAIT.
// - HALT wake-up works only if internal select is low at HALT entry.
// - After HALT wake-up in slave mode one extra exchange restores normal state.
// - All three events share one request, gated by enable and CPU mask.
// - Control bit 7 enables requests from done, fault and overrun flags.
// - Control bit 6 connects the pins; cleared by reset and by mode fault.
// - Control bit 4 selects master; cleared by hardware on mode fault.
// - Control bit 3 sets the serial clock idle level in master mode; the slave ignores it.
// - Control bit 2 selects first or second clock transition for capture.
// - Three rate bits divide the CPU clock by 4 to 128 in master mode.
// - Rate bits ignored in slave mode; bit 5 set selects divide by 4 or 32 with rate bits 00 or 10, else 128.
// - A slave with no new byte echoes the previously received byte.
// - Multi-master arbitration uses master select and mode-fault flag.
// - Status bit 7 set at completion; cleared by status then data access.
// - Status bit 5 set when a byte completes while bit 7 is still set.
// - Status bit 6 set by a data write during transfer; write discarded.
// - Status bit 1 makes select follow bit 0; bit 2 disables data output.
`include "spms_params.svh"
`timescale 1ns/1ps
`default_nettype none
module spms_port (
  // Clock and reset.
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_b,
  // Register port.
  input  wire logic [1:0]              i_addr,
  input  wire logic [7:0]              i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output var  logic [7:0]              o_rdata,
  // CPU low-power state and interrupt mask.
  input  wire logic                    i_halt,
  input  wire logic                    i_irq_mask,
  // Serial pins.
  input  wire spms_pkg::spms_pins_in_t  i_pins,
  output var  spms_pkg::spms_pins_out_t o_pins,
  // Interrupt request and wake-up requests.
  output var  logic                    o_irq,
  output var  logic                    o_wake_wait,
  output var  logic                    o_wake_halt
);

  logic                 rst_m;
  logic                 rst_s;
  logic [7:0]           ctrl;
  logic                 done_f, write_collision_flag_f, ovr_f, mode_fault_flag_f, data_output_disable, select_software_mode, select_software_level;
  logic [7:0]           shreg;
  logic [7:0]           rxbuf;
  logic [2:0]           bitcnt;
  logic                 phase;
  logic [6:0]           divcnt;
  logic                 sck_int;
  logic                 tx_q;
  logic                 sck_q;
  logic                 ss_q;
  logic                 stat_seen;
  logic                 mode_fault_flag_seen;
  logic                 halt_armed;
  logic                 halt_q;
  spms_pkg::spms_state_t state;

  // Reset is released through two flops; all logic uses the synced copy.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  // Decoding of the register port and of control fields.
  wire       wr_data   = i_wr && (i_addr == `SPMS_ADDR_DATA);
  wire       wr_ctrl   = i_wr && (i_addr == `SPMS_ADDR_CTRL);
  wire       wr_stat   = i_wr && (i_addr == `SPMS_ADDR_STAT);
  wire       rd_data   = i_rd && (i_addr == `SPMS_ADDR_DATA);
  wire       rd_stat   = i_rd && (i_addr == `SPMS_ADDR_STAT);
  wire       irq_en    = ctrl[`SPMS_CR_IRQ_EN];
  wire       out_en    = ctrl[`SPMS_CR_OUT_EN];
  wire       master    = ctrl[`SPMS_CR_MASTER];
  wire       idle_lvl  = ctrl[`SPMS_CR_IDLE_LVL];
  wire       capt_edge = ctrl[`SPMS_CR_CAPT_EDGE];
  wire [2:0] rate_code = {ctrl[`SPMS_CR_RATE_DIV], ctrl[1:0]};
  wire [7:0] stat_word = {done_f, write_collision_flag_f, ovr_f, mode_fault_flag_f, 1'b0, data_output_disable, select_software_mode, select_software_level};

  // Internal select follows the software level or the pin.
  wire       ss_int   = select_software_mode ? select_software_level : i_pins.ss_n_in;
  // Mode fault: select pulled low while master.
  wire       fault_ev = master && !ss_int;
  // HALT freezes the port unless a slave was armed at HALT entry.
  wire       active   = !i_halt || halt_armed;
  wire       busy     = (state == spms_pkg::SPMS_SHIFT);
  // The master divider keeps running through the closing half period too,
  // otherwise a phase 0 exchange could never give its last clock edge.
  wire       run_m    = (state != spms_pkg::SPMS_IDLE);
  wire       slave_on = out_en && !master && !ss_int && active;

  // Master half-period chosen from the rate bits; slave ignores them.
  logic [6:0] half_per;
  always_comb begin
    unique case (rate_code)
      3'b100:  half_per = `SPMS_HALF_DIV4;
      3'b000:  half_per = `SPMS_HALF_DIV8;
      3'b001:  half_per = `SPMS_HALF_DIV16;
      3'b110:  half_per = `SPMS_HALF_DIV32;
      3'b010:  half_per = `SPMS_HALF_DIV64;
      3'b011:  half_per = `SPMS_HALF_DIV128;
      default: half_per = `SPMS_HALF_DIV128;
    endcase
  end

  // Edge sources: master uses the divider, slave watches the sampled pin.
  wire m_tick    = master && run_m && active && (divcnt == half_per - 7'h01);
  wire s_edge    = slave_on && (i_pins.sck_in != sck_q);
  wire sck_edge  = m_tick || s_edge;
  // Capture on odd transitions when phase is 0, even ones when phase is 1.
  wire cap_now   = sck_edge && (phase == capt_edge);
  wire shift_now = sck_edge && (phase != capt_edge);
  wire rx_bit    = master ? i_pins.miso_in : i_pins.mosi_in;
  wire last_cap  = cap_now && (bitcnt == 3'h7);
  // Data writes are refused while busy or while the done flag stands.
  wire wr_ok     = wr_data && !busy && !done_f;
  wire start_m   = wr_ok && master && out_en;
  wire slv_start = s_edge && (state == spms_pkg::SPMS_IDLE);

  // Sequencer for one eight-bit exchange.
  always_ff @(posedge i_mclk or negedge rst_s) begin
    if (!rst_s) begin
      state  <= spms_pkg::SPMS_IDLE;
      bitcnt <= 3'h0;
      phase  <= 1'b0;
      divcnt <= 7'h00;
    end else begin
      unique case (state)
        spms_pkg::SPMS_IDLE: begin
          bitcnt <= 3'h0;
          phase  <= slv_start ? 1'b1 : 1'b0;
          divcnt <= 7'h00;
          if (start_m || slv_start) begin
            state <= spms_pkg::SPMS_SHIFT;
          end
        end
        spms_pkg::SPMS_SHIFT: begin
          divcnt <= m_tick ? 7'h00 : (active ? divcnt + 7'h01 : divcnt);
          if (sck_edge) begin
            phase <= ~phase;
          end
          if (cap_now) begin
            bitcnt <= bitcnt + 3'h1;
          end
          if (last_cap || !out_en) begin
            state <= spms_pkg::SPMS_DONE;
          end
        end
        spms_pkg::SPMS_DONE: begin
          // Phase 0 ends on a capture edge, so the master waits one more
          // half period for the edge that returns the clock to idle.
          if (!master || m_tick || capt_edge == 1'b1 || !out_en) begin
            state <= spms_pkg::SPMS_IDLE;
          end
          divcnt <= m_tick ? 7'h00 : divcnt + 7'h01;
          if (sck_edge) begin
            phase <= ~phase;
          end
        end
      endcase
    end
  end

  // Shift register: loaded by a data write, otherwise keeps the last
  // received byte so an unreloaded slave echoes it back.
  always_ff @(posedge i_mclk or negedge rst_s) begin
    if (!rst_s) begin
      shreg <= 8'h00;
    end else if (wr_ok) begin
      shreg <= i_wdata;
    end else if (cap_now) begin
      shreg <= {shreg[6:0], rx_bit};
    end
  end

  // Receive buffer takes the byte only when the done flag is clear.
  always_ff @(posedge i_mclk or negedge rst_s) begin
    if (!rst_s) begin
      rxbuf <= 8'h00;
    end else if (last_cap && !done_f) begin
      rxbuf <= {shreg[6:0], rx_bit};
    end
  end

  // Next clock level and next output bit reach the pins on the same edge
  // as the internal copies, so the far side sees no extra pipeline lag
  // and data only changes on shift edges, never on capture edges.
  wire sck_next = (run_m && master) ? (m_tick ? ~sck_int : sck_int) : idle_lvl;
  wire tx_next  = wr_ok ? i_wdata[7] :
                  (shift_now || state == spms_pkg::SPMS_IDLE) ? shreg[7] : tx_q;

  // Link-side sampled copies, the master serial clock level and output bit.
  always_ff @(posedge i_mclk or negedge rst_s) begin
    if (!rst_s) begin
      sck_q   <= 1'b0;
      ss_q    <= 1'b1;
      sck_int <= 1'b0;
      tx_q    <= 1'b0;
    end else begin
      sck_q   <= i_pins.sck_in;
      ss_q    <= ss_int;
      sck_int <= sck_next;
      tx_q    <= tx_next;
    end
  end

  // Control register; hardware clears enable and master on mode fault.
  // Setting either while the fault stands is blocked outside clearing.
  wire [7:0] ctrl_wr = (mode_fault_flag_f && !mode_fault_flag_seen) ? (i_wdata & 8'haf) : i_wdata;
  always_ff @(posedge i_mclk or negedge rst_s) begin
    if (!rst_s) begin
      ctrl <= `SPMS_CTRL_RESET;
    end else if (fault_ev) begin
      ctrl <= ctrl & 8'haf;
    end else if (wr_ctrl && !i_halt) begin
      ctrl <= ctrl_wr;
    end
  end

  // Status flags: a hardware set in the same cycle as a clear wins.
  wire clr_done = stat_seen && (rd_data || wr_data);
  wire clr_write_collision_flag = stat_seen && (rd_data || wr_data);
  wire clr_mode_fault_flag = mode_fault_flag_seen && wr_ctrl;
  wire set_ovr  = last_cap && done_f;
  always_ff @(posedge i_mclk or negedge rst_s) begin
    if (!rst_s) begin
      {done_f, write_collision_flag_f, ovr_f, mode_fault_flag_f} <= 4'h0;
      {data_output_disable, select_software_mode, select_software_level}                 <= 3'h0;
      stat_seen                       <= 1'b0;
      mode_fault_flag_seen                       <= 1'b0;
    end else begin
      done_f    <= last_cap || (done_f && !clr_done);
      write_collision_flag_f    <= (wr_data && busy) || (write_collision_flag_f && !clr_write_collision_flag);
      ovr_f     <= set_ovr || (ovr_f && !rd_stat);
      mode_fault_flag_f    <= fault_ev || (mode_fault_flag_f && !clr_mode_fault_flag);
      // Only a status access while the done flag stands arms the clear.
      stat_seen <= ((rd_stat || wr_stat) && done_f) ? 1'b1 :
                   (clr_done ? 1'b0 : stat_seen);
      mode_fault_flag_seen <= (rd_stat && mode_fault_flag_f) ? 1'b1 : (clr_mode_fault_flag ? 1'b0 : mode_fault_flag_seen);
      if (wr_stat && !i_halt) begin
        {data_output_disable, select_software_mode, select_software_level} <= i_wdata[2:0];
      end
    end
  end

  // Wake-up arm: caught on HALT entry when a slave is selected.
  always_ff @(posedge i_mclk or negedge rst_s) begin
    if (!rst_s) begin
      halt_q     <= 1'b0;
      halt_armed <= 1'b0;
    end else begin
      halt_q <= i_halt;
      if (i_halt && !halt_q) begin
        halt_armed <= !master && out_en && !ss_int;
      end else if (!i_halt && (master || !busy)) begin
        halt_armed <= 1'b0;
      end
    end
  end

  // Read data, request and pin drive are all registered outputs.
  wire [7:0] rd_mux = rd_stat ? stat_word :
                      rd_data ? rxbuf :
                      (i_rd && i_addr == `SPMS_ADDR_CTRL) ? ctrl : 8'h00;
  wire any_flag = done_f || mode_fault_flag_f || ovr_f;
  wire tx_bit   = tx_next;
  always_ff @(posedge i_mclk or negedge rst_s) begin
    if (!rst_s) begin
      o_rdata     <= 8'h00;
      o_irq       <= 1'b0;
      o_wake_wait <= 1'b0;
      o_wake_halt <= 1'b0;
      o_pins      <= '0;
    end else begin
      o_rdata         <= rd_mux;
      o_irq           <= irq_en && !i_irq_mask && any_flag;
      o_wake_wait     <= irq_en && any_flag;
      o_wake_halt     <= irq_en && done_f && !master && halt_armed;
      o_pins.sck_out  <= sck_next;
      o_pins.sck_oe   <= out_en && master;
      o_pins.mosi_out <= tx_bit;
      o_pins.mosi_oe  <= out_en && master && !data_output_disable;
      o_pins.miso_out <= tx_bit;
      o_pins.miso_oe  <= out_en && !master && !ss_int && !data_output_disable;
    end
  end

endmodule
`default_nettype wire

// *** spms_monitor.sv ***
/* Checker for the serial port, seeing only the top module's ports.
   Assumes a bind from the bench and that the design resets on i_rst_b. */
`timescale 1ns/1ps
`default_nettype none
module spms_monitor (
  // Clock, reset and register port.
  input wire logic                     i_mclk,
  input wire logic                     i_rst_b,
  input wire logic [1:0]               i_addr,
  input wire logic [7:0]               i_wdata,
  input wire logic                     i_wr,
  input wire logic                     i_rd,
  input wire logic [7:0]               o_rdata,
  // CPU state and pins.
  input wire logic                     i_halt,
  input wire logic                     i_irq_mask,
  input wire spms_pkg::spms_pins_in_t  i_pins,
  input wire spms_pkg::spms_pins_out_t o_pins,
  // Requests.
  input wire logic                     o_irq,
  input wire logic                     o_wake_wait,
  input wire logic                     o_wake_halt
);
  logic [7:0] ctl_q;
  logic       sod_q;
  logic       sck_q;
  logic [7:0] idle_n;
  wire        ctl_wr = i_wr && !i_halt && i_addr == 2'h2;

  // Shadow of software writes; hardware only clears control bits, so implications stay safe.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl_q  <= 8'h00;
      sod_q  <= 1'b0;
      sck_q  <= 1'b0;
      idle_n <= 8'h00;
    end else begin
      sck_q <= o_pins.sck_out;
      if (ctl_wr) ctl_q <= i_wdata;
      if (i_wr && !i_halt && i_addr == 2'h3) sod_q <= i_wdata[2];
      if (ctl_wr || sck_q != o_pins.sck_out) idle_n <= 8'h00;
      else if (idle_n != 8'hc8) idle_n <= idle_n + 8'h01;
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  // Requests and wake-ups must agree with their gating.
  a_irq_wakes_wait: assert property (o_irq |-> o_wake_wait)
    else $error("irq without wait wake-up");
  a_mask_blocks_irq: assert property (i_irq_mask [*3] |-> !o_irq)
    else $error("irq while masked");
  a_irq_needs_enable: assert property (
    o_irq |-> ctl_q[7] || $past(ctl_q[7]) || $past(ctl_q[7], 2))
    else $error("irq while disabled");
  a_halt_wake_done: assert property (o_wake_halt |-> o_wake_wait)
    else $error("halt wake-up without flag");
  a_rdata_one_cycle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  // Pins follow the enables with at most two cycles of lag.
  a_sck_out_master: assert property (
    o_pins.sck_oe |-> ctl_q[4] || $past(ctl_q[4]) || $past(ctl_q[4], 2))
    else $error("clock driven in slave mode");
  a_oe_needs_enable: assert property (
    o_pins.mosi_oe || o_pins.miso_oe |-> ctl_q[6] || $past(ctl_q[6]) || $past(ctl_q[6], 2))
    else $error("data pin driven while disabled");
  a_sck_idle_level: assert property (
    idle_n == 8'hc8 && o_pins.sck_oe |-> o_pins.sck_out == ctl_q[3])
    else $error("clock idle level wrong");
  a_output_disable: assert property (
    o_pins.mosi_oe |-> !(sod_q && $past(sod_q) && $past(sod_q, 2)))
    else $error("data output driven while disabled");

  c_irq: cover property (o_irq);
  c_master_drive: cover property (o_pins.sck_oe && o_pins.mosi_oe);
  c_done_read: cover property ($past(i_rd) && $past(i_addr) == 2'h3 && o_rdata[7]);
endmodule
`default_nettype wire

// *** spms_slave_model.sv ***
/* Far-side slave for the port in master mode: returns a byte while selected.
   Assumes sck and mosi are settled levels sampled on i_clk. */
`timescale 1ns/1ps
`default_nettype none
module spms_slave_model (
  // Clock and link.
  input  wire logic       i_clk,
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_sel_n,
  // Setup from the bench, same phase as the master.
  input  wire logic       i_capture_edge_select,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic [7:0]      o_rx
);
  logic [4:0] edges;
  logic       sck_q;
  logic       last;
  int         idx;

  // Both phases drive bit 7 from selection on, since (-1)/2 truncates to 0; an undriven line flips every cycle.
  assign idx    = i_capture_edge_select ? (int'(edges) - 1) / 2 : int'(edges) / 2;
  assign o_miso = (i_sel_n || idx < 0 || idx > 7) ? ~last : i_tx[7 - idx];

  // Capture on odd transitions for phase 0 and even ones for phase 1.
  always_ff @(posedge i_clk) begin
    sck_q <= i_sck;
    last  <= o_miso;
    if (i_sel_n) begin
      edges <= 5'h00;
    end else if (sck_q != i_sck) begin
      edges <= edges + 5'h01;
      if (edges[0] == i_capture_edge_select) o_rx <= {o_rx[6:0], i_mosi};
    end
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
/* Bench for the serial port in master mode against a far-side slave.
   Assumes the monitor and slave model are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                     i_mclk = 1'b0;
  logic                     i_rst_b = 1'b0;
  logic [1:0]               i_addr = 2'h0;
  logic [7:0]               i_wdata = 8'h00;
  logic                     i_wr = 1'b0;
  logic                     i_rd = 1'b0;
  logic                     i_halt = 1'b0;
  logic                     i_irq_mask = 1'b0;
  logic                     ss_n = 1'b1;
  logic                     sel_n = 1'b1;
  logic                     clock_idle_level = 1'b0;
  logic                     capture_edge_select = 1'b0;
  logic [7:0]               stx = 8'h00;
  logic [7:0]               o_rdata, srx;
  logic                     miso, o_irq, o_wake_wait, o_wake_halt;
  spms_pkg::spms_pins_out_t o_pins;
  spms_pkg::spms_pins_in_t  pins_in;
  int                       n_mismatch = 0;
  int                       comparisons = 0;

  // Released lines rest at their pulls: clock at the idle level, data high.
  assign pins_in = {o_pins.sck_oe ? o_pins.sck_out : clock_idle_level,
                    o_pins.mosi_oe ? o_pins.mosi_out : 1'b1, miso, ss_n};
  always #50 i_mclk = ~i_mclk;

  spms_port dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_halt(i_halt), .i_irq_mask(i_irq_mask),
    .i_pins(pins_in), .o_pins(o_pins), .o_irq(o_irq), .o_wake_wait(o_wake_wait),
    .o_wake_halt(o_wake_halt));
  spms_slave_model far_u (.i_clk(i_mclk), .i_sck(pins_in.sck_in), .i_mosi(pins_in.mosi_in),
    .i_sel_n(sel_n), .i_capture_edge_select(capture_edge_select), .i_tx(stx), .o_miso(miso), .o_rx(srx));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask
  task automatic chk_reg(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1 chk(what, o_rdata, exp);
  endtask
  // Counts clock edges until the serial clock changes, bounded against a hang.
  task automatic sck_gap(output int n);
    logic s;
    s = o_pins.sck_out;
    n = 0;
    do begin
      @(posedge i_mclk);
      #1 n++;
    end while (o_pins.sck_out === s && n < 400);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Transfers take about two thousand cycles; twenty thousand means a hang.
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_mismatch++;
    results();
  end

  initial begin
    logic [7:0] tx, ctl;
    logic [2:0] rate [6];
    int         n;
    rate = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
    repeat (12) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk_reg(2'h2, 8'h00, "ctrl reset");
    chk_reg(2'h3, 8'h00, "status reset");
    chk_reg(2'h0, 8'h00, "unmapped read");
    // All six divide ratios, every polarity and phase; collision, blocked write and mask on the way.
    for (int i = 0; i < 6; i++) begin
      ctl = {3'b111, 1'b1, i[1], i[0], rate[i][1:0]};
      ctl[5] = rate[i][2];
      tx = 8'h5a ^ 8'(i * 37);
      wr_reg(2'h2, 8'h00);
      clock_idle_level <= i[1];
      capture_edge_select <= i[0];
      stx <= ~tx;
      i_irq_mask <= (i == 5);
      wr_reg(2'h2, ctl);
      repeat (3) @(posedge i_mclk);
      chk("sck idle", {7'h00, o_pins.sck_out}, {7'h00, i[1]});
      sel_n <= 1'b0;
      wr_reg(2'h1, tx);
      sck_gap(n);
      sck_gap(n);
      chk("half period", 8'(n), 8'(2 << i));
      if (i == 1) wr_reg(2'h1, 8'h00);
      n = 0;
      while (o_wake_wait !== 1'b1 && n < 3000) begin
        @(posedge i_mclk);
        #1 n++;
      end
      chk("irq", {7'h00, o_irq}, {7'h00, i != 5});
      if (i == 2) wr_reg(2'h1, 8'hff);
      chk_reg(2'h3, (i == 1) ? 8'hc0 : 8'h80, "status done");
      chk_reg(2'h1, ~tx, "rx byte");
      chk("far rx", srx, tx);
      chk_reg(2'h3, 8'h00, "status cleared");
      sel_n <= 1'b1;
    end
    @(posedge i_mclk) i_halt <= 1'b1;
    wr_reg(2'h2, 8'h00);
    i_halt <= 1'b0;
    chk_reg(2'h2, ctl, "frozen in halt");
    i_irq_mask <= 1'b0;
    wr_reg(2'h3, 8'h03);
    wr_reg(2'h2, 8'hd0);
    @(posedge i_mclk) ss_n <= 1'b0;
    repeat (4) @(posedge i_mclk);
    chk_reg(2'h3, 8'h03, "soft deselect");
    wr_reg(2'h3, 8'h02);
    repeat (4) @(posedge i_mclk);
    chk_reg(2'h3, 8'h12, "mode fault");
    chk("fault irq", {7'h00, o_irq}, 8'h01);
    chk_reg(2'h2, 8'h80, "fault ctrl");
    ss_n <= 1'b1;
    wr_reg(2'h3, 8'h00);
    chk_reg(2'h3, 8'h10, "fault held");
    wr_reg(2'h2, 8'h00);
    chk_reg(2'h3, 8'h00, "fault cleared");
    results();
  end
endmodule

bind spms_port spms_monitor mon_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_halt(i_halt),
  .i_irq_mask(i_irq_mask), .i_pins(i_pins), .o_pins(o_pins), .o_irq(o_irq),
  .o_wake_wait(o_wake_wait), .o_wake_halt(o_wake_halt));
`default_nettype wire
